// ===== hdl/ccm_pkg.sv
`default_nettype none
package ccm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0  = 8'h00; // sys_clock_ctrl0
    localparam logic [7:0] OFS_CTRL1  = 8'h04; // sys_clock_ctrl1
    localparam logic [7:0] OFS_CTRL2  = 8'h08; // osc_stop_detect_ctrl
    localparam logic [7:0] OFS_PCLK   = 8'h0C; // periph_clock_select_reg
    localparam logic [7:0] OFS_ROC    = 8'h10; // onchip_osc_ctrl
    localparam logic [7:0] OFS_STATUS = 8'h14; // mode status, read only

    // sys_clock_ctrl0 fields
    localparam int B_CLOCK_OUTPUT_PIN_LO   = 0;
    localparam int B_CLOCK_OUTPUT_PIN_HI   = 1;
    localparam int B_PSTOP_WAIT  = 2;
    localparam int B_SUB_OSC_EN  = 4;
    localparam int B_MAIN_OFF    = 5;
    localparam int B_DIV8        = 6;
    localparam int B_SUB_SEL     = 7;
    // sys_clock_ctrl1 fields
    localparam int B_STOP_REQ    = 0;
    localparam int B_PLL_SEL     = 1;
    localparam int B_DIV_LO      = 6;
    localparam int B_DIV_HI      = 7;
    // osc_stop_detect_ctrl field
    localparam int B_ONCHIP_SEL  = 1;
    // periph_clock_select_reg field
    localparam int B_F1_OUT      = 5;
    // onchip_osc_ctrl field width
    localparam int ROC_FREQ_W    = 4;

    // values after reset: on-chip oscillator, divide by 16
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'hC0;
    localparam logic [7:0] RST_CTRL2 = 8'h02;
    localparam logic [7:0] RST_PCLK  = 8'h00;
    localparam logic [7:0] RST_ROC   = 8'h00;

    // divider terminal counts (ratio minus one)
    localparam logic [3:0] LIM_DIV1  = 4'h0;
    localparam logic [3:0] LIM_DIV2  = 4'h1;
    localparam logic [3:0] LIM_DIV4  = 4'h3;
    localparam logic [3:0] LIM_DIV8  = 4'h7;
    localparam logic [3:0] LIM_DIV16 = 4'hF;
    localparam logic [4:0] SUB_TIMER_CLOCK_LIM  = 5'h1F;
    localparam int         SYNC_LEN  = 3;

    // oscillator source indices
    typedef enum logic [1:0] {
        SRC_MAIN   = 2'h0,
        SRC_SUB    = 2'h1,
        SRC_ONCHIP = 2'h2,
        SRC_PLL    = 2'h3
    } ccm_src_t;

    // operating modes, one-hot
    typedef enum logic [8:0] {
        M_HIGH   = 9'h001,
        M_MEDIUM = 9'h002,
        M_PLL    = 9'h004,
        M_LOW    = 9'h008,
        M_LOWPWR = 9'h010,
        M_ROC    = 9'h020,
        M_ROC_LP = 9'h040,
        M_WAIT   = 9'h080,
        M_STOP   = 9'h100
    } ccm_mode_t;

    // avalon request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } ccm_avl_req_t;

    // peripheral clock enables
    typedef struct packed {
        logic f1;
        logic f2;
        logic f8;
        logic f32;
    } ccm_fi_t;
endpackage
`default_nettype wire

// ===== hdl/ccm_cpu_div.sv
`default_nettype none
module ccm_cpu_div (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // requested source and ratio
    input  wire logic [3:0] src_edge,
    input  wire logic [1:0] src_sel,
    input  wire logic [3:0] limit,
    input  wire logic       run,
    // cpu clock enable
    output logic            cpu_en
);
    logic [1:0] cur_src_r, cur_src_nxt;
    logic [3:0] cur_lim_r, cur_lim_nxt;
    logic [3:0] cnt_r,     cnt_nxt;
    logic       en_r,      en_nxt;
    logic       edge_now;

    // new source and ratio taken at a period boundary, or every cycle while run is low
    always_comb begin
        cur_src_nxt = cur_src_r;
        cur_lim_nxt = cur_lim_r;
        cnt_nxt     = cnt_r;
        en_nxt      = 1'b0;
        edge_now    = src_edge[cur_src_r];
        if (!run) begin
            cnt_nxt     = 4'h0;
            cur_src_nxt = src_sel;
            cur_lim_nxt = limit;
        end else if (edge_now) begin
            if (cnt_r >= cur_lim_r) begin
                cnt_nxt     = 4'h0;
                en_nxt      = 1'b1;
                cur_src_nxt = src_sel;  // no runt pulses
                cur_lim_nxt = limit;
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_src_r <= ccm_pkg::SRC_ONCHIP;   // on-chip oscillator
            cur_lim_r <= ccm_pkg::LIM_DIV16;    // divide by 16
            cnt_r     <= 4'h0;
            en_r      <= 1'b0;
        end else begin
            cur_src_r <= cur_src_nxt;
            cur_lim_r <= cur_lim_nxt;
            cnt_r     <= cnt_nxt;
            en_r      <= en_nxt;
        end
    end

    assign cpu_en = en_r;
endmodule
`default_nettype wire

// ===== hdl/ccm_clock_ctrl.sv
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module ccm_clock_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // avalon-mm slave
    input  wire ccm_pkg::ccm_avl_req_t avl_req,
    output logic [31:0]               avl_readdata,
    output logic                      avl_waitrequest,
    // oscillator levels from the pads
    input  wire logic                 main_osc,
    input  wire logic                 sub_osc,
    input  wire logic                 onchip_osc,
    input  wire logic                 pll_osc,
    // power control from the cpu, same clock
    input  wire logic                 wait_req,
    input  wire logic                 wake,
    // general port data for the shared pin
    input  wire logic                 port9_bit0_out,
    input  wire logic                 port9_bit0_oe_n,
    // oscillator enables
    output logic                      main_osc_run,
    output logic                      sub_osc_run,
    output logic                      onchip_osc_run,
    output logic [3:0]                onchip_osc_freq_sel,
    // generated clock enables
    output logic                      cpu_clk_en,
    output ccm_pkg::ccm_fi_t          fi_en,
    output ccm_pkg::ccm_fi_t          fsio_en,
    output logic                      converter_clock,
    output logic                      sub_timer_clock,
    // clock output pin
    output logic                      clock_output_pin,
    output logic                      clock_output_oe_n,
    // current mode
    output ccm_pkg::ccm_mode_t        mode
);
    // decode a register field into a divider terminal count
    function automatic logic [3:0] div_limit(input logic d8,
                                             input logic [1:0] fld);
        if (d8) begin
            div_limit = ccm_pkg::LIM_DIV8;
        end else begin
            unique case (fld)
                2'b00: div_limit = ccm_pkg::LIM_DIV1;
                2'b01: div_limit = ccm_pkg::LIM_DIV2;
                2'b10: div_limit = ccm_pkg::LIM_DIV4;
                2'b11: div_limit = ccm_pkg::LIM_DIV16;
            endcase
        end
    endfunction

    // register file and pad state
    logic [7:0]             ctrl0_r, ctrl0_nxt;
    logic [7:0]             ctrl1_r, ctrl1_nxt;
    logic [7:0]             ctrl2_r, ctrl2_nxt;
    logic [7:0]             pclk_r,  pclk_nxt;
    logic [7:0]             roc_r,   roc_nxt;
    logic                   wreq_r,  wreq_nxt;
    logic [31:0]            rdata_r, rdata_nxt;
    logic [3:0][2:0]        sync_r,  sync_nxt;
    logic [3:0]             lvl_r,   lvl_nxt;
    logic [3:0]             edge_r,  edge_nxt;
    ccm_pkg::ccm_mode_t     mode_r,  mode_nxt;
    logic [4:0]             pcnt_r,  pcnt_nxt;
    logic [4:0]             ccnt_r,  ccnt_nxt;
    ccm_pkg::ccm_fi_t       fi_r,    fi_nxt;
    logic                   fad_r,   fad_nxt;
    logic                   sub_timer_clock_r,  sub_timer_clock_nxt;
    logic                   pin_r,   pin_nxt;
    logic                   oe_n_r,  oe_n_nxt;
    logic                   run_r,   run_nxt;
    logic [2:0]             osc_en_r, osc_en_nxt;
    logic [1:0]             cpu_src;
    logic [3:0]             cpu_lim;
    logic                   take;
    logic                   stopped;
    logic                   p_edge;
    logic                   p_gate;
    logic [2:0]             out_code;
    logic                   div_cpu_en;

    // bus handshake: one wait cycle, then the access takes effect
    assign take = (avl_req.read | avl_req.write) & ~wreq_r;
    always_comb begin
        wreq_nxt  = ~((avl_req.read | avl_req.write) & wreq_r);
        rdata_nxt = 32'h0000_0000;
        unique case (avl_req.address)
            ccm_pkg::OFS_CTRL0:  rdata_nxt[7:0] = ctrl0_r;
            ccm_pkg::OFS_CTRL1:  rdata_nxt[7:0] = ctrl1_r;
            ccm_pkg::OFS_CTRL2:  rdata_nxt[7:0] = ctrl2_r;
            ccm_pkg::OFS_PCLK:   rdata_nxt[7:0] = pclk_r;
            ccm_pkg::OFS_ROC:    rdata_nxt[7:0] = roc_r;
            ccm_pkg::OFS_STATUS: rdata_nxt[8:0] = mode_r;
            default:             rdata_nxt      = 32'h0000_0000;
        endcase
    end

    // register writes and hardware updates of control bits
    always_comb begin
        ctrl0_nxt = ctrl0_r;
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        pclk_nxt  = pclk_r;
        roc_nxt   = roc_r;
        // wake from stop clears the stop bit
        if (wake && mode_r == ccm_pkg::M_STOP) begin
            ctrl1_nxt[ccm_pkg::B_STOP_REQ] = 1'b0;
        end
        if (take && avl_req.write) begin
            unique case (avl_req.address)
                ccm_pkg::OFS_CTRL0: begin
                    ctrl0_nxt = avl_req.writedata[7:0];
                    if (mode_r == ccm_pkg::M_LOWPWR) begin
                        // div8 held in low power mode
                        ctrl0_nxt[ccm_pkg::B_DIV8] =
                            ctrl0_r[ccm_pkg::B_DIV8];
                    end
                    if (mode_r == ccm_pkg::M_LOW &&
                        avl_req.writedata[ccm_pkg::B_MAIN_OFF]) begin
                        ctrl0_nxt[ccm_pkg::B_DIV8] = 1'b1;
                    end
                end
                ccm_pkg::OFS_CTRL1: begin
                    ctrl1_nxt = avl_req.writedata[7:0];
                    // pll only taken from high speed mode
                    if (mode_r != ccm_pkg::M_HIGH &&
                        mode_r != ccm_pkg::M_PLL) begin
                        ctrl1_nxt[ccm_pkg::B_PLL_SEL] = 1'b0;
                    end
                    if (avl_req.writedata[ccm_pkg::B_STOP_REQ]) begin
                        // pll must be left before stop
                        if (mode_r == ccm_pkg::M_PLL) begin
                            ctrl1_nxt[ccm_pkg::B_STOP_REQ] = 1'b0;
                        end
                        if (mode_r == ccm_pkg::M_HIGH ||
                            mode_r == ccm_pkg::M_MEDIUM ||
                            mode_r == ccm_pkg::M_ROC ||
                            mode_r == ccm_pkg::M_ROC_LP) begin
                            ctrl0_nxt[ccm_pkg::B_DIV8] = 1'b1;
                        end
                    end
                end
                ccm_pkg::OFS_CTRL2: ctrl2_nxt = avl_req.writedata[7:0];
                ccm_pkg::OFS_PCLK:  pclk_nxt  = avl_req.writedata[7:0];
                ccm_pkg::OFS_ROC:   roc_nxt   = avl_req.writedata[7:0];
                default:            ;
            endcase
        end
    end

    // pad synchronisers; a level counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sync_nxt[i] = {sync_r[i][1:0], 1'b0};
        end
        sync_nxt[0][0] = main_osc;
        sync_nxt[1][0] = sub_osc;
        sync_nxt[2][0] = onchip_osc;
        sync_nxt[3][0] = pll_osc;
        for (int i = 0; i < 4; i++) begin
            lvl_nxt[i]  = lvl_r[i];
            edge_nxt[i] = 1'b0;
            if (sync_r[i][1] == sync_r[i][2]) begin
                lvl_nxt[i]  = sync_r[i][2];
                edge_nxt[i] = sync_r[i][2] & ~lvl_r[i];
            end
        end
    end

    // operating mode from the control bits and power requests
    always_comb begin
        if (ctrl1_r[ccm_pkg::B_STOP_REQ]) begin
            mode_nxt = ccm_pkg::M_STOP;
        end else if (wait_req && mode_r != ccm_pkg::M_PLL) begin
            mode_nxt = ccm_pkg::M_WAIT;
        end else if (ctrl0_r[ccm_pkg::B_SUB_SEL]) begin
            mode_nxt = ctrl0_r[ccm_pkg::B_MAIN_OFF] ?
                       ccm_pkg::M_LOWPWR : ccm_pkg::M_LOW;
        end else if (ctrl2_r[ccm_pkg::B_ONCHIP_SEL]) begin
            mode_nxt = ctrl0_r[ccm_pkg::B_MAIN_OFF] ?
                       ccm_pkg::M_ROC_LP : ccm_pkg::M_ROC;
        end else if (ctrl1_r[ccm_pkg::B_PLL_SEL]) begin
            mode_nxt = ccm_pkg::M_PLL;
        end else if (cpu_lim == ccm_pkg::LIM_DIV1) begin
            mode_nxt = ccm_pkg::M_HIGH;
        end else begin
            mode_nxt = ccm_pkg::M_MEDIUM;
        end
    end

    // cpu source: sub overrides, then on-chip, then pll, else main
    always_comb begin
        cpu_lim = div_limit(ctrl0_r[ccm_pkg::B_DIV8],
                            ctrl1_r[ccm_pkg::B_DIV_HI:ccm_pkg::B_DIV_LO]);
        if (ctrl0_r[ccm_pkg::B_SUB_SEL]) begin
            cpu_src = ccm_pkg::SRC_SUB;
            cpu_lim = ccm_pkg::LIM_DIV1;
        end else if (ctrl2_r[ccm_pkg::B_ONCHIP_SEL]) begin
            cpu_src = ccm_pkg::SRC_ONCHIP;
        end else if (ctrl1_r[ccm_pkg::B_PLL_SEL]) begin
            cpu_src = ccm_pkg::SRC_PLL;
            cpu_lim = ccm_pkg::LIM_DIV1;
        end else begin
            cpu_src = ccm_pkg::SRC_MAIN;
        end
    end

    // oscillator enables follow the control bits on the same edge
    assign osc_en_nxt = {~ctrl0_nxt[ccm_pkg::B_MAIN_OFF],
                         ctrl0_nxt[ccm_pkg::B_SUB_OSC_EN],
                         ctrl2_nxt[ccm_pkg::B_ONCHIP_SEL]} &
                        {3{~ctrl1_nxt[ccm_pkg::B_STOP_REQ]}};

    // cpu clock stops in wait and stop; a source being switched off
    // makes the divider reload at once, as no old edge will come
    assign stopped = (mode_r == ccm_pkg::M_STOP);
    assign run_nxt = ~stopped & (mode_r != ccm_pkg::M_WAIT) &
                     ~|(osc_en_r & ~osc_en_nxt);

    ccm_cpu_div u_cpu_div (
        .clk      (clk),
        .rst      (rst),
        .src_edge (edge_r),
        .src_sel  (cpu_src),
        .limit    (cpu_lim),
        .run      (run_r),
        .cpu_en   (div_cpu_en)
    );

    // peripheral clocks from main, pll or on-chip, with gating
    always_comb begin
        if (ctrl2_r[ccm_pkg::B_ONCHIP_SEL]) begin
            p_edge = edge_r[ccm_pkg::SRC_ONCHIP];
        end else if (ctrl1_r[ccm_pkg::B_PLL_SEL]) begin
            p_edge = edge_r[ccm_pkg::SRC_PLL];
        end else begin
            p_edge = edge_r[ccm_pkg::SRC_MAIN];
        end
        p_gate = stopped | (mode_r == ccm_pkg::M_LOWPWR) |
                 ((mode_r == ccm_pkg::M_WAIT) &
                  ctrl0_r[ccm_pkg::B_PSTOP_WAIT]);
        pcnt_nxt = pcnt_r;
        fi_nxt   = '0;
        fad_nxt  = 1'b0;
        if (p_edge && !p_gate) begin
            pcnt_nxt   = pcnt_r + 5'h01;
            fi_nxt.f1  = 1'b1;
            fi_nxt.f2  = pcnt_r[0];
            fi_nxt.f8  = &pcnt_r[2:0];
            fi_nxt.f32 = &pcnt_r;
            fad_nxt    = 1'b1;
        end
    end

    // sub timer clock, sub clock divided by 32, only while it runs
    always_comb begin
        ccnt_nxt = ccnt_r;
        sub_timer_clock_nxt = 1'b0;
        if (edge_r[ccm_pkg::SRC_SUB] && sub_osc_run && !stopped) begin
            ccnt_nxt = ccnt_r + 5'h01;
            sub_timer_clock_nxt = (ccnt_r == ccm_pkg::SUB_TIMER_CLOCK_LIM);
        end
    end

    // clock output pin: toggles on the selected enable
    assign out_code = {pclk_r[ccm_pkg::B_F1_OUT],
                       ctrl0_r[ccm_pkg::B_CLOCK_OUTPUT_PIN_HI],
                       ctrl0_r[ccm_pkg::B_CLOCK_OUTPUT_PIN_LO]};
    always_comb begin
        pin_nxt  = pin_r;
        oe_n_nxt = 1'b0;
        unique case (out_code)
            3'h1: pin_nxt = pin_r ^ edge_r[ccm_pkg::SRC_SUB];
            3'h2: pin_nxt = pin_r ^ fi_nxt.f8;
            3'h3: pin_nxt = pin_r ^ fi_nxt.f32;
            3'h4: pin_nxt = pin_r ^ fi_nxt.f1;
            default: begin
                // port mode; forbidden codes fall back to the port
                pin_nxt  = port9_bit0_out;
                oe_n_nxt = port9_bit0_oe_n;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl0_r <= ccm_pkg::RST_CTRL0;
            ctrl1_r <= ccm_pkg::RST_CTRL1;
            ctrl2_r <= ccm_pkg::RST_CTRL2;
            pclk_r  <= ccm_pkg::RST_PCLK;
            roc_r   <= ccm_pkg::RST_ROC;
            wreq_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
            sync_r  <= '0;
            lvl_r   <= 4'h0;
            edge_r  <= 4'h0;
            mode_r  <= ccm_pkg::M_ROC;
            pcnt_r  <= 5'h00;
            ccnt_r  <= 5'h00;
            fi_r    <= '0;
            fad_r   <= 1'b0;
            sub_timer_clock_r  <= 1'b0;
            pin_r   <= 1'b0;
            oe_n_r  <= 1'b1;
            run_r   <= 1'b0;
            osc_en_r <= {~ccm_pkg::RST_CTRL0[ccm_pkg::B_MAIN_OFF],
                         ccm_pkg::RST_CTRL0[ccm_pkg::B_SUB_OSC_EN],
                         ccm_pkg::RST_CTRL2[ccm_pkg::B_ONCHIP_SEL]};
        end else begin
            ctrl0_r <= ctrl0_nxt;
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            pclk_r  <= pclk_nxt;
            roc_r   <= roc_nxt;
            wreq_r  <= wreq_nxt;
            rdata_r <= rdata_nxt;
            sync_r  <= sync_nxt;
            lvl_r   <= lvl_nxt;
            edge_r  <= edge_nxt;
            mode_r  <= mode_nxt;
            pcnt_r  <= pcnt_nxt;
            ccnt_r  <= ccnt_nxt;
            fi_r    <= fi_nxt;
            fad_r   <= fad_nxt;
            sub_timer_clock_r  <= sub_timer_clock_nxt;
            pin_r   <= pin_nxt;
            oe_n_r  <= oe_n_nxt;
            run_r   <= run_nxt;
            osc_en_r <= osc_en_nxt;
        end
    end

    // outputs
    assign avl_readdata        = rdata_r;
    assign avl_waitrequest     = wreq_r;
    assign main_osc_run        = osc_en_r[2];
    assign sub_osc_run         = osc_en_r[1];
    assign onchip_osc_run      = osc_en_r[0];
    assign onchip_osc_freq_sel = roc_r[ccm_pkg::ROC_FREQ_W-1:0];
    assign cpu_clk_en          = div_cpu_en;
    assign fi_en               = fi_r;
    assign fsio_en             = fi_r;
    assign converter_clock     = fad_r;
    assign sub_timer_clock     = sub_timer_clock_r;
    assign clock_output_pin    = pin_r;
    assign clock_output_oe_n   = oe_n_r;
    assign mode                = mode_r;
endmodule
`default_nettype wire

// ===== dv/ccm_clock_ctrl_chk.sv
`default_nettype none
module ccm_clock_ctrl_chk (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // register bus
    input wire ccm_pkg::ccm_avl_req_t avl_req,
    input wire logic                  avl_waitrequest,
    // clocks and mode
    input wire logic                  main_osc_run,
    input wire logic                  sub_osc_run,
    input wire logic                  cpu_clk_en,
    input wire ccm_pkg::ccm_fi_t      fi_en,
    input wire ccm_pkg::ccm_fi_t      fsio_en,
    input wire logic                  converter_clock,
    input wire logic                  sub_timer_clock,
    input wire logic                  clock_output_pin,
    input wire ccm_pkg::ccm_mode_t    mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // bus answers one cycle after a request, for one cycle
    bus_answer_a: assert property ((avl_req.read || avl_req.write) &&
        avl_waitrequest |=> !avl_waitrequest ##1 avl_waitrequest)
        else $error("waitrequest timing wrong");
    runt_free_a: assert property (
        cpu_clk_en |=> !cpu_clk_en) else $error("cpu enable runt");
    sio_match_a: assert property (
        fsio_en == fi_en) else $error("serial clocks differ");
    conv_f1_a: assert property (
        converter_clock == fi_en.f1) else $error("converter clock off");
    fi_nest_a: assert property (
        fi_en.f2 || fi_en.f8 || fi_en.f32 |-> fi_en.f1)
        else $error("divided clock without f1");
    lowpwr_gate_a: assert property (
        (mode == ccm_pkg::M_LOWPWR) [*3] |-> fi_en == '0 &&
        !converter_clock) else $error("clocks run in low power");
    main_stop_a: assert property (
        mode inside {ccm_pkg::M_LOWPWR, ccm_pkg::M_ROC_LP}
        |-> !$past(main_osc_run)) else $error("main clock left on");
    pll_entry_a: assert property (
        $rose(mode == ccm_pkg::M_PLL) |-> $past(mode) == ccm_pkg::M_HIGH)
        else $error("pll mode not entered from high");
    reset_mode_a: assert property (
        $fell(rst) |-> mode == ccm_pkg::M_ROC) else $error("reset mode");
    sub_gate_a: assert property (
        (!sub_osc_run) [*8] |-> !sub_timer_clock)
        else $error("sub timer clock without sub clock");
    // main scenarios
    pll_c: cover property (mode == ccm_pkg::M_PLL);
    lowpwr_c: cover property (mode == ccm_pkg::M_LOWPWR);
    sub_c: cover property (sub_timer_clock);
    pin_c: cover property ($changed(clock_output_pin));
endmodule
bind ccm_clock_ctrl ccm_clock_ctrl_chk chk (.clk, .rst, .avl_req,
    .avl_waitrequest, .main_osc_run, .sub_osc_run, .cpu_clk_en, .fi_en,
    .fsio_en, .converter_clock, .sub_timer_clock, .clock_output_pin, .mode);
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst = 1, wait_req = 0, wake = 0, p9o = 1, p9e = 1;
    logic main_osc, sub_osc, onchip_osc, pll_osc, pin_q = 0, tgl;
    logic m_run, s_run, o_run, cpu, conv, stc, pin, oe_n, wrq;
    logic [31:0] rdata, q;
    logic [3:0] fsel;
    ccm_pkg::ccm_avl_req_t req = '0;
    ccm_pkg::ccm_fi_t fi, fs;
    ccm_pkg::ccm_mode_t mode;
    int cyc = 0, n_fail = 0, n_tests = 0, n;
    int dv[4] = '{1, 2, 4, 16};
    int cp[4] = '{14, 64, 256, 8};
    logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv[7] = '{32'h0, 32'hC0, 32'h2, 32'h0, 32'h0, 32'h20, 32'h0};
    ccm_clock_ctrl dut (.clk, .rst, .avl_req(req), .avl_readdata(rdata),
        .avl_waitrequest(wrq), .main_osc, .sub_osc, .onchip_osc, .pll_osc,
        .wait_req, .wake, .port9_bit0_out(p9o), .port9_bit0_oe_n(p9e),
        .main_osc_run(m_run), .sub_osc_run(s_run), .onchip_osc_run(o_run),
        .onchip_osc_freq_sel(fsel), .cpu_clk_en(cpu), .fi_en(fi),
        .fsio_en(fs), .converter_clock(conv), .sub_timer_clock(stc),
        .clock_output_pin(pin), .clock_output_oe_n(oe_n), .mode);
    // pad oscillators, low while disabled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pin_q <= pin;
        main_osc <= m_run && (cyc % 8 < 4);
        pll_osc <= cyc % 6 < 3;
        onchip_osc <= o_run && (cyc % 10 < 5);
        sub_osc <= s_run && (cyc % 14 < 7);
    end
    assign tgl = pin ^ pin_q;
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= '{!w, w, a, d};
        do begin
            @(posedge clk);
            k++;
        end while (wrq !== 1'b0 && k < 50);
        q = rdata;
        req <= '0;
        @(posedge clk);
        if (k >= 50) chk(k, 0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    function automatic logic pk(int k);
        case (k)
            0: return cpu;
            1: return fi.f1;
            2: return fi.f8;
            3: return fi.f32;
            4: return stc;
            default: return tgl;
        endcase
    endfunction
    // cycles to the next pulse, capped at 2000
    task ev(input int k, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pk(k) !== 1'b1 && c < 2000);
    endtask
    task per(input int k, input int e);
        int c;
        repeat (3) ev(k, c);
        chk(c, e);
    endtask
    initial begin
        #400000;
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rv[i]);
        chk({m_run, s_run, o_run}, 3'b101);
        per(0, 160);
        per(1, 10);
        wr(ccm_pkg::OFS_ROC, 32'h5);
        chk(fsel, 4'h5);
        for (int i = 0; i < 4; i++) begin
            wr(ccm_pkg::OFS_CTRL1, 32'(i << 6));
            per(0, 10 * dv[i]);
        end
        wr(ccm_pkg::OFS_CTRL0, 32'h40);
        per(0, 80);
        wr(ccm_pkg::OFS_CTRL2, 32'h0);
        rd(ccm_pkg::OFS_STATUS, 32'h002);
        per(0, 64);
        wr(ccm_pkg::OFS_CTRL1, 32'h2);
        rd(ccm_pkg::OFS_CTRL1, 32'h0);
        wr(ccm_pkg::OFS_CTRL0, 32'h10);
        rd(ccm_pkg::OFS_STATUS, 32'h001);
        per(0, 8);
        per(2, 64);
        per(3, 256);
        per(4, 448);
        wr(ccm_pkg::OFS_CTRL1, 32'h2);
        rd(ccm_pkg::OFS_STATUS, 32'h004);
        per(0, 6);
        per(1, 6);
        wr(ccm_pkg::OFS_CTRL1, 32'h3);
        rd(ccm_pkg::OFS_CTRL1, 32'h2);
        wr(ccm_pkg::OFS_CTRL1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ccm_pkg::OFS_PCLK, 32'((i + 1) >> 2) << 5);
            wr(ccm_pkg::OFS_CTRL0, 32'h10 | 32'((i + 1) & 3));
            per(5, cp[i]);
            chk(oe_n, 1'b0);
        end
        p9o <= 1'b0;
        wr(ccm_pkg::OFS_CTRL0, 32'h11);
        repeat (3) @(posedge clk);
        chk({pin, oe_n}, 2'b01);
        wr(ccm_pkg::OFS_PCLK, 32'h0);
        wr(ccm_pkg::OFS_CTRL0, 32'h90);
        rd(ccm_pkg::OFS_STATUS, 32'h008);
        per(0, 14);
        per(1, 8);
        wr(ccm_pkg::OFS_CTRL0, 32'hB0);
        rd(ccm_pkg::OFS_STATUS, 32'h010);
        rd(ccm_pkg::OFS_CTRL0, 32'hF0);
        chk(m_run, 1'b0);
        ev(1, n);
        chk(n, 2000);
        per(4, 448);
        wr(ccm_pkg::OFS_CTRL0, 32'hB0);
        rd(ccm_pkg::OFS_CTRL0, 32'hF0);
        wr(ccm_pkg::OFS_CTRL0, 32'hD0);
        wr(ccm_pkg::OFS_CTRL0, 32'h50);
        per(0, 64);
        wr(ccm_pkg::OFS_CTRL0, 32'h10);
        wr(ccm_pkg::OFS_CTRL1, 32'h1);
        rd(ccm_pkg::OFS_STATUS, 32'h100);
        rd(ccm_pkg::OFS_CTRL0, 32'h50);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        rd(ccm_pkg::OFS_STATUS, 32'h002);
        wr(ccm_pkg::OFS_CTRL0, 32'h14);
        wait_req <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ccm_pkg::OFS_STATUS, 32'h080);
        ev(1, n);
        chk(n, 2000);
        per(4, 448);
        wait_req <= 1'b0;
        wr(ccm_pkg::OFS_CTRL2, 32'h2);
        wr(ccm_pkg::OFS_CTRL0, 32'h20);
        rd(ccm_pkg::OFS_STATUS, 32'h040);
        per(0, 10);
        per(1, 10);
        chk(mode, 9'h040);
        give_verdict;
    end
endmodule
`default_nettype wire
